//--- design/sac_ctrl.sv
// converter control: power-up, conversion timing, mode sampling and serial readout
`timescale 1ns/100ps
module sac_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // converter pins
  input wire logic convert_start_n,
  input wire logic ext_ref,
  input wire logic [sac_pkg::DATA_W-1:0] sample_code,
  // serial link
  input wire logic serial_shift_clock,
  output logic receive_frame_sync,
  output logic serial_data_out,
  output logic serial_data_oe,
  // status
  output logic powered
);
  import sac_pkg::*;

  // ------------------------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------------------------
  logic cs_s1_q, cs_s2_q, cs_s3_q, sk_s1_q, sk_s2_q, sk_s3_q, ext_s1_q, ext_s2_q;
  logic cs_s1_d, cs_s2_d, cs_s3_d, sk_s1_d, sk_s2_d, sk_s3_d, ext_s1_d, ext_s2_d;
  logic [DATA_W-1:0] code_s1_q, code_s2_q, code_s1_d, code_s2_d;
  logic cs_rise, cs_fall, sk_rise, sk_fall;

  always_comb begin
    cs_s1_d = convert_start_n;
    cs_s2_d = cs_s1_q;
    cs_s3_d = cs_s2_q;
    sk_s1_d = serial_shift_clock;
    sk_s2_d = sk_s1_q;
    sk_s3_d = sk_s2_q;
    ext_s1_d = ext_ref;
    ext_s2_d = ext_s1_q;
    code_s1_d = sample_code;
    code_s2_d = code_s1_q;
    cs_rise = cs_s2_q & ~cs_s3_q;
    cs_fall = ~cs_s2_q & cs_s3_q;
    sk_rise = sk_s2_q & ~sk_s3_q;
    sk_fall = ~sk_s2_q & sk_s3_q;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sk_s1_q <= 1'b0;
      sk_s2_q <= 1'b0;
      sk_s3_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      code_s1_q <= RES_ZERO;
      code_s2_q <= RES_ZERO;
    end else begin
      cs_s1_q <= cs_s1_d;
      cs_s2_q <= cs_s2_d;
      cs_s3_q <= cs_s3_d;
      sk_s1_q <= sk_s1_d;
      sk_s2_q <= sk_s2_d;
      sk_s3_q <= sk_s3_d;
      ext_s1_q <= ext_s1_d;
      ext_s2_q <= ext_s2_d;
      code_s1_q <= code_s1_d;
      code_s2_q <= code_s2_d;
    end
  end

  // ------------------------------------------------------------
  // power and conversion sequencer
  // ------------------------------------------------------------
  sac_pwr_t st_q, st_d;
  logic [TMR_W-1:0] pu_q, pu_d;
  logic [TMR_W-1:0] cv_q, cv_d;
  logic pend_q, pend_d;
  logic [DATA_W-1:0] res_q, res_d;
  logic eoc_q, eoc_d;
  logic pwr_q, pwr_d;
  logic [TMR_W-1:0] pu_lim;

  always_comb begin
    pu_lim = ext_s2_q ? TMR_W'(PWRUP_EXT_CYC) : TMR_W'(PWRUP_INT_CYC);
    st_d = st_q;
    pu_d = pu_q;
    cv_d = cv_q;
    pend_d = pend_q;
    res_d = res_q;
    eoc_d = 1'b0;
    // mode sample timer runs from each conversion start (fall in READY, or end of wake-up), independent of serial clock
    if (cv_q != '0) begin
      cv_d = cv_q + TMR_W'(1);
      if (cv_q == TMR_W'(CONV_CYC)) begin
        res_d = code_s2_q;
        eoc_d = 1'b1;
      end
      if (cv_q == TMR_W'(SAMPLE_CYC)) begin
        cv_d = '0;
      end
    end
    unique case (st_q)
      SAC_OFF: begin
        if (cs_rise) begin
          st_d = SAC_WAKE;
          pu_d = TMR_W'(1);
          pend_d = 1'b0;
        end
      end
      SAC_WAKE: begin
        pu_d = pu_q + TMR_W'(1);
        if (cs_fall) begin
          pend_d = 1'b1;
        end
        if (pu_q >= pu_lim) begin
          if (pend_q || cs_fall) begin
            st_d = SAC_CONV;
            cv_d = TMR_W'(1);
            pend_d = 1'b0;
          end else begin
            st_d = SAC_READY;
          end
        end
      end
      SAC_READY: begin
        if (cs_fall) begin
          st_d = SAC_CONV;
          cv_d = TMR_W'(1);
        end
      end
      SAC_CONV: begin
        if (cv_q == TMR_W'(SAMPLE_CYC)) begin
          st_d = cs_s2_q ? SAC_READY : SAC_OFF;
        end
      end
      default: st_d = SAC_OFF;
    endcase
    pwr_d = (st_d != SAC_OFF);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SAC_OFF;
      pu_q <= '0;
      cv_q <= '0;
      pend_q <= 1'b0;
      res_q <= RES_ZERO;
      eoc_q <= 1'b0;
      pwr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pu_q <= pu_d;
      cv_q <= cv_d;
      pend_q <= pend_d;
      res_q <= res_d;
      eoc_q <= eoc_d;
      pwr_q <= pwr_d;
    end
  end

  // ------------------------------------------------------------
  // serial readout (independent of power state)
  // ------------------------------------------------------------
  logic arm_q, arm_d;
  logic [3:0] bit_q, bit_d;
  logic [DATA_W-1:0] sh_q, sh_d;
  logic fs_q, fs_d, do_q, do_d, oe_q, oe_d;

  always_comb begin
    arm_d = arm_q | eoc_q;
    bit_d = bit_q;
    sh_d = sh_q;
    fs_d = fs_q;
    do_d = do_q;
    oe_d = oe_q;
    if (sk_rise) begin
      if (arm_q && fs_q) begin
        fs_d = 1'b0;
        oe_d = 1'b1;
        do_d = res_q[DATA_W-1];
        sh_d = {res_q[DATA_W-2:0], 1'b0};
        bit_d = 4'h1;
        arm_d = eoc_q;
      end else if (!fs_q) begin
        bit_d = bit_q + 4'h1;
        if (bit_q < BIT_LAST) begin
          do_d = sh_q[DATA_W-1];
          sh_d = {sh_q[DATA_W-2:0], 1'b0};
        end
        if (bit_q == BIT_LAST) begin
          fs_d = 1'b1;
          bit_d = '0;
        end
      end
    end
    if (sk_fall && !fs_q && bit_q == BIT_LAST) begin
      oe_d = 1'b0;
    end
    if (cs_fall && !fs_q) begin
      fs_d = 1'b1;
      oe_d = 1'b0;
      bit_d = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 1'b0;
      bit_q <= '0;
      sh_q <= RES_ZERO;
      fs_q <= 1'b1;
      do_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      fs_q <= fs_d;
      do_q <= do_d;
      oe_q <= oe_d;
    end
  end

  assign receive_frame_sync = fs_q;
  assign serial_data_out = do_q;
  assign serial_data_oe = oe_q;
  assign powered = pwr_q;
endmodule

//--- design/sac_pkg.sv
// package: timing constants and states for the converter control block
package sac_pkg;
  localparam int CLK_NS = 5;
  localparam int PWRUP_EXT_NS = 1000;
  localparam int PWRUP_INT_NS = 25000;
  localparam int CONV_NS = 330;
  localparam int SAMPLE_NS = 530;
  // least times round up
  localparam int PWRUP_EXT_CYC = (PWRUP_EXT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_INT_CYC = (PWRUP_INT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic [DATA_W-1:0] RES_ZERO = 8'h00;

  typedef enum logic [3:0] {
    SAC_OFF = 4'b0001,
    SAC_WAKE = 4'b0010,
    SAC_READY = 4'b0100,
    SAC_CONV = 4'b1000
  } sac_pwr_t;
endpackage

//--- test/sac_ctrl_chk.sv
// checker: port assertions for sac_ctrl
`timescale 1ns/100ps
module sac_ctrl_chk
  import sac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // inputs
  input wire logic convert_start_n,
  input wire logic serial_shift_clock,
  // outputs
  input wire logic receive_frame_sync,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic powered
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  oe_in_frame_a: assert property (serial_data_oe |-> !receive_frame_sync)
    else $error("oe outside frame");
  sync_start_a: assert property ($fell(receive_frame_sync) |->
    $past(serial_shift_clock, 2) && serial_data_oe) else $error("bad frame start");
  sync_end_a: assert property ($rose(receive_frame_sync) |-> !serial_data_oe &&
    ($past(serial_shift_clock, 2) || !$past(convert_start_n, 2))) else $error("bad frame end");
  bit_shift_a: assert property ($changed(serial_data_out) && serial_data_oe |->
    $past(serial_shift_clock, 2)) else $error("data moved off rise");
  data_release_a: assert property ($fell(serial_data_oe) |->
    !$past(serial_shift_clock, 2) || !$past(convert_start_n, 2)) else $error("bad release");
  wake_up_a: assert property ($rose(convert_start_n) |-> ##[1:8] powered)
    else $error("no wake");
  wake_cause_a: assert property ($rose(powered) |-> $past(convert_start_n, 2))
    else $error("woke alone");
  power_down_a: assert property ($fell(powered) |-> !$past(convert_start_n, 3))
    else $error("bad power down");
  cover property ($rose(receive_frame_sync));
  cover property ($fell(serial_data_oe));
  cover property ($fell(powered));
endmodule
bind sac_ctrl sac_ctrl_chk sac_ctrl_chk_inst (.mclk(mclk), .rst_b(rst_b),
  .convert_start_n(convert_start_n), .serial_shift_clock(serial_shift_clock),
  .receive_frame_sync(receive_frame_sync), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe), .powered(powered));

//--- test/sac_master.sv
// serial master model: shift-clock bursts, capture on falling edges
`timescale 1ns/100ps
module sac_master (
  // control
  input wire logic go,
  input wire logic [3:0] n_clk,
  // serial link
  input wire logic sdo,
  output logic sclk,
  output logic [7:0] rx
);
  initial begin
    sclk = 1'b0;
    rx = 8'h00;
    forever begin
      wait (go);
      #1.3;
      for (int i = 0; i < n_clk; i++) begin
        sclk = 1'b1;
        #80 sclk = 1'b0;
        if (i < 8) rx = {rx[6:0], sdo};
        #80;
      end
      wait (!go);
    end
  end
endmodule

//--- test/tb.sv
// testbench for sac_ctrl
`timescale 1ns/100ps
module tb;
  import sac_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_n = 1'b0;
  logic ext_ref = 1'b1;
  logic [7:0] code = 8'h00;
  logic go = 1'b0;
  logic [3:0] n_clk = 4'h9;
  logic sclk, sync, sdo, oe, pwr;
  logic [7:0] rx;
  wire sdo_w;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cyc = 0;
  always #2.5 mclk = ~mclk;
  assign sdo_w = oe ? sdo : 1'bz;
  sac_ctrl sac_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .convert_start_n(cs_n),
    .ext_ref(ext_ref), .sample_code(code), .serial_shift_clock(sclk),
    .receive_frame_sync(sync), .serial_data_out(sdo), .serial_data_oe(oe), .powered(pwr));
  sac_master sac_master_inst (.go(go), .n_clk(n_clk), .sdo(sdo_w), .sclk(sclk), .rx(rx));
  task cy(int n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(logic [7:0] g, logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd(logic [3:0] n);
    n_clk = n;
    go = 1'b1;
    cy(32 * n + 4);
    go = 1'b0;
    cy(8);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task t_ext;
    rd(4'h9);
    chk(rx, 8'hzz);
    chk(8'(sync), 8'h1);
    chk(8'(pwr), 8'h0);
    code = 8'ha5;
    cs_n = 1'b1;
    cy(10);
    chk(8'(pwr), 8'h1);
    cs_n = 1'b0;
    cy(230);
    chk(8'(pwr), 8'h1);
    cy(150);
    chk(8'(pwr), 8'h0);
    rd(4'h9);
    chk(rx, 8'ha5);
    chk(8'(sync), 8'h1);
    $display("t_ext end");
  endtask
  task t_fast;
    code = 8'h3c;
    cs_n = 1'b1;
    cy(250);
    cs_n = 1'b0;
    cy(20);
    cs_n = 1'b1;
    cy(100);
    chk(8'(pwr), 8'h1);
    rd(4'h8);
    chk(rx, 8'h3c);
    chk(8'(sync), 8'h0);
    chk(8'(oe), 8'h0);
    code = 8'h81;
    cs_n = 1'b0;
    cy(8);
    chk(8'(sync), 8'h1);
    cs_n = 1'b1;
    cy(150);
    rd(4'h9);
    chk(rx, 8'h81);
    $display("t_fast end");
  endtask
  task t_int;
    cs_n = 1'b0;
    cy(150);
    chk(8'(pwr), 8'h0);
    ext_ref = 1'b0;
    code = 8'hff;
    cs_n = 1'b1;
    cy(5010);
    cs_n = 1'b0;
    cy(20);
    cs_n = 1'b1;
    cy(100);
    rd(4'h9);
    chk(rx, 8'hff);
    $display("t_int end");
  endtask
  initial begin
    cy(4);
    rst_b = 1'b1;
    cy(2);
    t_ext;
    t_fast;
    t_int;
    test_done;
  end
  always @(posedge mclk) begin
    n_cyc++;
    if (n_cyc > 20000) begin
      n_mismatch++;
      test_done;
    end
  end
endmodule
